// >>> verilog/crfs_pkg.sv
/*
 Package for the clock, reset flag and clock select block: register offsets,
 bit positions, reset values and the state carrier types.
 Assumes an 8-bit register port with byte offsets as printed.
*/
package crfs_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] CRFS_OFS_FLAGS = 8'h37;
    localparam logic [7:0] CRFS_OFS_INTEN = 8'h38;
    localparam logic [7:0] CRFS_OFS_CLKSEL = 8'h39;
    // ----------------------------------------
    // Flags register bits
    // ----------------------------------------
    localparam int CRFS_B_TICKF = 7;
    localparam int CRFS_B_POWER_ON_RESET_FLAG = 6;
    localparam int CRFS_B_LOW_VOLTAGE_RESET_FLAG = 5;
    localparam int CRFS_B_LOCKF = 4;
    localparam int CRFS_B_LOCK = 3;
    localparam int CRFS_B_ILLEGAL_ADDRESS_RESET_FLAG = 2;
    localparam int CRFS_B_OSCF = 1;
    localparam int CRFS_B_OSCQ = 0;
    // ----------------------------------------
    // Interrupt enable register bits
    // ----------------------------------------
    localparam int CRFS_B_TICKIE = 7;
    localparam int CRFS_B_LOCK_CHANGE_INTERRUPT_ENABLE = 4;
    localparam int CRFS_B_OSCILLATOR_INTERRUPT_ENABLE = 1;
    localparam int CRFS_B_PLLLOSS = 0;
    // ----------------------------------------
    // Clock select register bits
    // ----------------------------------------
    localparam int CRFS_B_SYSSEL = 7;
    localparam int CRFS_B_PSTOP = 6;
    localparam int CRFS_B_SAD = 5;
    localparam int CRFS_B_WDSEL1 = 4;
    localparam int CRFS_B_TICKPSE = 3;
    localparam int CRFS_B_WDPSE = 2;
    localparam int CRFS_B_TICKSEL = 1;
    localparam int CRFS_B_WDSEL0 = 0;
    // ----------------------------------------
    // Reset values, divider and ACLK sync constants
    // ----------------------------------------
    localparam logic [7:0] CRFS_CLKSEL_RST = 8'h80;
    localparam logic [7:0] CRFS_INTEN_RST = 8'h00;
    localparam logic [4:0] CRFS_UNLOCK_DIV = 5'h03;
    localparam int CRFS_ACLK_SYNC_CYC = 2;
    localparam logic [1:0] CRFS_ACLK_SYNC = 2'h2;

    typedef struct packed {
        logic tick_timeout_flag;
        logic power_on_reset_flag;
        logic low_voltage_reset_flag;
        logic lock_change_flag;
        logic illegal_address_reset_flag;
        logic oscillator_change_flag;
        logic pll_clock_loss_reset_flag;
        logic [7:0] inten;
        logic [7:0] clksel;
        logic wd_lower_lost;
        logic lock_seen;
        logic oscq_seen;
        logic stop_seen;
        logic [1:0] aclk_cnt;
        logic aclk_gate;
        logic [7:0] rdata;
        logic irq;
        logic tick_restart;
        logic wd_restart;
        logic tick_run;
        logic wd_run;
        logic osc_enable;
        logic sys_from_pll;
        logic [4:0] pll_div;
        logic [1:0] wd_src;
        logic tick_src;
    } crfs_state_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } crfs_bus_s;
endpackage

// >>> verilog/crfs_top.sv
/*
 Reset cause flags, PLL and oscillator status, interrupt enables and the
 system, tick and watchdog clock selects.
 Assumes inputs synchronous to ref_clk; power-on and low-voltage resets are
 reported as one-cycle pulses once this logic runs again after them.
*/
// Our own choice: strobed register access.
`timescale 1ns/1ns
module crfs_top (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Register port
    input wire crfs_pkg::crfs_bus_s bus,
    output logic [7:0] rdata,
    // Reset causes and events
    input wire logic por_event,
    input wire logic lvr_event,
    input wire logic ila_event,
    input wire logic pll_loss_event,
    input wire logic tick_period_end,
    // Status and mode
    input wire logic pll_locked,
    input wire logic osc_qualified,
    input wire logic special_mode,
    input wire logic write_protect,
    input wire logic wd_write_once_done,
    input wire logic stop_mode,
    input wire logic wd_aclk_tick,
    input wire logic [4:0] pll_post_divider,
    // Interrupt request and outputs to the clock tree
    output logic irq,
    output logic sys_from_pll,
    output logic [4:0] pll_div,
    output logic osc_enable,
    output logic tick_src,
    output logic [1:0] wd_src,
    output logic tick_run,
    output logic wd_run,
    output logic aclk_gate,
    output logic tick_restart,
    output logic wd_restart
);
    import crfs_pkg::*;

    crfs_state_s s_reg;
    crfs_state_s s_next;
    logic oscq;
    logic full_stop;
    logic wr_flags;
    logic wr_inten;
    logic wr_clk;
    logic [7:0] wv;
    logic [7:0] cs;
    logic lockable;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_next = s_reg;
        wv = bus.wdata;
        full_stop = stop_mode && !s_reg.clksel[CRFS_B_PSTOP];
        oscq = osc_qualified && !full_stop;
        wr_flags = bus.wr && bus.addr == CRFS_OFS_FLAGS;
        wr_inten = bus.wr && bus.addr == CRFS_OFS_INTEN;
        wr_clk = bus.wr && bus.addr == CRFS_OFS_CLKSEL && !write_protect;
        lockable = !special_mode && wd_write_once_done;
        cs = s_reg.clksel;

        // Write one clears, then hardware sets so an event is never lost
        if (wr_flags) begin
            if (wv[CRFS_B_TICKF]) s_next.tick_timeout_flag = 1'b0;
            if (wv[CRFS_B_POWER_ON_RESET_FLAG]) s_next.power_on_reset_flag = 1'b0;
            if (wv[CRFS_B_LOW_VOLTAGE_RESET_FLAG]) s_next.low_voltage_reset_flag = 1'b0;
            if (wv[CRFS_B_LOCKF]) s_next.lock_change_flag = 1'b0;
            if (wv[CRFS_B_ILLEGAL_ADDRESS_RESET_FLAG]) s_next.illegal_address_reset_flag = 1'b0;
            if (wv[CRFS_B_OSCF]) s_next.oscillator_change_flag = 1'b0;
        end
        if (wr_inten) begin
            s_next.inten = wv & 8'h92;
            if (wv[CRFS_B_PLLLOSS]) s_next.pll_clock_loss_reset_flag = 1'b0;
        end
        if (tick_period_end) s_next.tick_timeout_flag = 1'b1;
        if (por_event) begin
            s_next.power_on_reset_flag = 1'b1;
            s_next.illegal_address_reset_flag = 1'b0;
            s_next.pll_clock_loss_reset_flag = 1'b0;
        end
        if (por_event || lvr_event) s_next.low_voltage_reset_flag = 1'b1;
        if (ila_event && !por_event) s_next.illegal_address_reset_flag = 1'b1;
        if (pll_loss_event && !por_event) s_next.pll_clock_loss_reset_flag = 1'b1;
        s_next.lock_seen = pll_locked;
        if (pll_locked != s_reg.lock_seen) s_next.lock_change_flag = 1'b1;
        s_next.oscq_seen = oscq;
        if (oscq != s_reg.oscq_seen) s_next.oscillator_change_flag = 1'b1;

        // Clock select writes
        if (wr_clk) begin
            cs[CRFS_B_PSTOP] = wv[CRFS_B_PSTOP];
            cs[CRFS_B_TICKPSE] = wv[CRFS_B_TICKPSE];
            cs[CRFS_B_WDPSE] = wv[CRFS_B_WDPSE];
            cs[CRFS_B_SYSSEL] = wv[CRFS_B_SYSSEL] || !oscq;
            cs[CRFS_B_TICKSEL] = wv[CRFS_B_TICKSEL] && oscq;
            if (!lockable) begin
                cs[CRFS_B_SAD] = wv[CRFS_B_SAD];
                cs[CRFS_B_WDSEL1] = wv[CRFS_B_WDSEL1];
            end
            if (!lockable || (s_reg.wd_lower_lost && wv[CRFS_B_WDSEL0])) begin
                cs[CRFS_B_WDSEL0] = wv[CRFS_B_WDSEL0] && oscq;
                if (wv[CRFS_B_WDSEL0] && oscq) s_next.wd_lower_lost = 1'b0;
            end
        end
        // Loss of qualification overrides; upper watchdog select survives it
        if (!oscq) begin
            cs[CRFS_B_SYSSEL] = 1'b1;
            cs[CRFS_B_TICKSEL] = 1'b0;
            if (cs[CRFS_B_WDSEL0]) s_next.wd_lower_lost = 1'b1;
            cs[CRFS_B_WDSEL0] = 1'b0;
        end
        s_next.clksel = cs;
        s_next.tick_restart = cs[CRFS_B_TICKSEL] != s_reg.clksel[CRFS_B_TICKSEL];
        s_next.wd_restart = (cs[CRFS_B_WDSEL1] != s_reg.clksel[CRFS_B_WDSEL1])
            || (!cs[CRFS_B_WDSEL1] && cs[CRFS_B_WDSEL0] != s_reg.clksel[CRFS_B_WDSEL0]);

        // Clock sources and dividers
        s_next.sys_from_pll = cs[CRFS_B_SYSSEL];
        s_next.pll_div = pll_locked ? pll_post_divider : CRFS_UNLOCK_DIV;
        s_next.tick_src = cs[CRFS_B_TICKSEL];
        s_next.wd_src = cs[CRFS_B_WDSEL1] ? 2'h2 : {1'b0, cs[CRFS_B_WDSEL0]};
        s_next.osc_enable = !stop_mode || cs[CRFS_B_PSTOP];

        // Stop mode counters: frozen unless pseudo-stop enables them or the watchdog runs on ACLK, never cleared
        s_next.tick_run = !stop_mode || (cs[CRFS_B_PSTOP] && cs[CRFS_B_TICKPSE]
            && cs[CRFS_B_TICKSEL]);
        s_next.wd_run = !stop_mode || cs[CRFS_B_WDSEL1]
            || (cs[CRFS_B_PSTOP] && cs[CRFS_B_WDPSE] && cs[CRFS_B_WDSEL0]);

        // ACLK gating waits two aclk ticks so the watchdog sees stop cleanly
        s_next.stop_seen = stop_mode;
        if (!stop_mode) begin
            s_next.aclk_cnt = 2'h0;
            s_next.aclk_gate = 1'b0;
        end else if (cs[CRFS_B_SAD] && cs[CRFS_B_WDSEL1] && !s_reg.aclk_gate) begin
            if (wd_aclk_tick) s_next.aclk_cnt = s_reg.aclk_cnt + 2'h1;
            if (wd_aclk_tick && s_reg.aclk_cnt + 2'h1 == CRFS_ACLK_SYNC)
                s_next.aclk_gate = 1'b1;
        end

        // Interrupt request and read data
        s_next.irq = (s_next.tick_timeout_flag && s_next.inten[CRFS_B_TICKIE])
            || (s_next.lock_change_flag && s_next.inten[CRFS_B_LOCK_CHANGE_INTERRUPT_ENABLE])
            || (s_next.oscillator_change_flag && s_next.inten[CRFS_B_OSCILLATOR_INTERRUPT_ENABLE]);
        s_next.rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                CRFS_OFS_FLAGS: s_next.rdata = {s_reg.tick_timeout_flag,
                    s_reg.power_on_reset_flag, s_reg.low_voltage_reset_flag,
                    s_reg.lock_change_flag, pll_locked, s_reg.illegal_address_reset_flag,
                    s_reg.oscillator_change_flag, s_reg.oscq_seen};
                CRFS_OFS_INTEN: s_next.rdata = {s_reg.inten[7:1],
                    s_reg.pll_clock_loss_reset_flag};
                CRFS_OFS_CLKSEL: s_next.rdata = s_reg.clksel;
                default: s_next.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg <= '0;
            s_reg.clksel <= CRFS_CLKSEL_RST;
            s_reg.inten <= CRFS_INTEN_RST;
            s_reg.sys_from_pll <= 1'b1;
            s_reg.pll_div <= CRFS_UNLOCK_DIV;
            s_reg.osc_enable <= 1'b1;
            s_reg.tick_run <= 1'b1;
            s_reg.wd_run <= 1'b1;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    assign rdata = s_reg.rdata;
    assign irq = s_reg.irq;
    assign sys_from_pll = s_reg.sys_from_pll;
    assign pll_div = s_reg.pll_div;
    assign osc_enable = s_reg.osc_enable;
    assign tick_src = s_reg.tick_src;
    assign wd_src = s_reg.wd_src;
    assign tick_run = s_reg.tick_run;
    assign wd_run = s_reg.wd_run;
    assign aclk_gate = s_reg.aclk_gate;
    assign tick_restart = s_reg.tick_restart;
    assign wd_restart = s_reg.wd_restart;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    tick_flag_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && tick_period_end |=> s_reg.tick_timeout_flag)
        else $error("tick flag not set");
    zero_write_keeps_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && wr_flags && !wv[CRFS_B_POWER_ON_RESET_FLAG] && s_reg.power_on_reset_flag
        |=> s_reg.power_on_reset_flag)
        else $error("flag lost on zero write");
    por_flag_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && por_event |=> s_reg.power_on_reset_flag && s_reg.low_voltage_reset_flag)
        else $error("power-on flags not set");
    ila_por_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && por_event |=> !s_reg.illegal_address_reset_flag)
        else $error("illegal address flag not cleared");
    lock_toggle_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && $changed(pll_locked) && $past(clk_en) ##1 clk_en |=> s_reg.lock_change_flag)
        else $error("lock change missed");
    protect_blocks_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && bus.wr && bus.addr == CRFS_OFS_CLKSEL && write_protect && oscq
        |=> s_reg.clksel[CRFS_B_PSTOP] == $past(s_reg.clksel[CRFS_B_PSTOP]))
        else $error("protected write took effect");
    sys_sel_osc_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && !oscq |=> s_reg.clksel[CRFS_B_SYSSEL] && !s_reg.clksel[CRFS_B_TICKSEL])
        else $error("select not forced on oscillator loss");
    wd_src_map_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && $past(clk_en) |-> wd_src == ($past(s_next.clksel[CRFS_B_WDSEL1]) ? 2'h2
        : {1'b0, $past(s_next.clksel[CRFS_B_WDSEL0])}))
        else $error("watchdog source wrong");
    irq_enable_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_reg.tick_timeout_flag && s_reg.inten[CRFS_B_TICKIE] && $past(clk_en) |-> irq)
        else $error("tick irq missing");
endmodule

// >>> tb/crfs_tb_top.sv
/*
 Self-checking bench for crfs_top: register access tasks, event pulses and level changes.
 Assumes the package and the design module are compiled first.
*/
`timescale 1ns/1ns
module crfs_tb_top;
    import crfs_pkg::*;
    // --------------------
    // Stimulus and wiring
    // --------------------
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    crfs_bus_s bus = '0;
    logic [5:0] ev = 6'h00;
    logic lk = 1'b0, oq = 1'b0, sp = 1'b1, wp = 1'b0, wo = 1'b0, st = 1'b0;
    logic [7:0] rdata;
    logic irq, sys_from_pll, osc_enable, tick_src, tick_run, wd_run, aclk_gate;
    logic tick_restart, wd_restart;
    logic ce = 1'b1;
    logic [4:0] pll_div;
    logic [1:0] wd_src;
    int mismatches = 0, n_tests = 0, cycles = 0;

    always #4 ref_clk = ~ref_clk;

    crfs_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(ce), .bus(bus), .rdata(rdata),
        .por_event(ev[0]), .lvr_event(ev[1]), .ila_event(ev[2]), .pll_loss_event(ev[3]),
        .tick_period_end(ev[4]), .pll_locked(lk), .osc_qualified(oq), .special_mode(sp),
        .write_protect(wp), .wd_write_once_done(wo), .stop_mode(st), .wd_aclk_tick(ev[5]),
        .pll_post_divider(5'h07), .irq(irq), .sys_from_pll(sys_from_pll), .pll_div(pll_div),
        .osc_enable(osc_enable), .tick_src(tick_src), .wd_src(wd_src), .tick_run(tick_run),
        .wd_run(wd_run), .aclk_gate(aclk_gate), .tick_restart(tick_restart),
        .wd_restart(wd_restart));
    // --------------------
    // Tasks
    // --------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // Ends just past an edge so registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus <= '0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus <= '0;
        #1;
        check(rdata, exp, what);
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge ref_clk);
        ev <= m;
        @(posedge ref_clk);
        ev <= 6'h00;
    endtask
    task automatic done(input string t);
        $display("test %s finished", t);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // --------------------
    // Tests
    // --------------------
    // Ceiling well above the fewer than two hundred cycles the tests need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(CRFS_OFS_FLAGS, 8'h00, "flags");
        rd(CRFS_OFS_INTEN, CRFS_INTEN_RST, "inten");
        rd(CRFS_OFS_CLKSEL, CRFS_CLKSEL_RST, "clksel");
        rd(8'h3A, 8'h00, "unmapped");
        check({3'h0, pll_div}, 8'h03, "pll_div");
        done("reset");
        pulse(6'h04);
        pulse(6'h01);
        rd(CRFS_OFS_FLAGS, 8'h60, "flags");
        pulse(6'h04);
        pulse(6'h10);
        rd(CRFS_OFS_FLAGS, 8'hE4, "flags");
        wr(CRFS_OFS_FLAGS, 8'h00);
        rd(CRFS_OFS_FLAGS, 8'hE4, "flags");
        wr(CRFS_OFS_FLAGS, 8'h64);
        rd(CRFS_OFS_FLAGS, 8'h80, "flags");
        check({7'h00, irq}, 8'h00, "irq");
        wr(CRFS_OFS_INTEN, 8'h80);
        cyc(2);
        check({7'h00, irq}, 8'h01, "irq");
        @(posedge ref_clk);
        ev <= 6'h10;
        bus <= '{CRFS_OFS_FLAGS, 8'h80, 1'b1, 1'b0};
        @(posedge ref_clk);
        ev <= 6'h00;
        bus <= '0;
        rd(CRFS_OFS_FLAGS, 8'h80, "flags");
        wr(CRFS_OFS_FLAGS, 8'h80);
        cyc(2);
        check({7'h00, irq}, 8'h00, "irq");
        pulse(6'h02);
        rd(CRFS_OFS_FLAGS, 8'h20, "flags");
        wr(CRFS_OFS_FLAGS, 8'h20);
        pulse(6'h08);
        rd(CRFS_OFS_INTEN, 8'h81, "inten");
        wr(CRFS_OFS_INTEN, 8'h00);
        rd(CRFS_OFS_INTEN, 8'h01, "inten");
        pulse(6'h01);
        rd(CRFS_OFS_INTEN, 8'h00, "inten");
        wr(CRFS_OFS_FLAGS, 8'h60);
        // Enable low must swallow the tick pulse
        @(posedge ref_clk) ce <= 1'b0;
        pulse(6'h10);
        @(posedge ref_clk) ce <= 1'b1;
        rd(CRFS_OFS_FLAGS, 8'h00, "frozen flags");
        done("flags");
        @(posedge ref_clk) lk <= 1'b1;
        cyc(3);
        rd(CRFS_OFS_FLAGS, 8'h18, "flags");
        check({3'h0, pll_div}, 8'h07, "pll_div");
        wr(CRFS_OFS_INTEN, 8'h10);
        cyc(2);
        check({7'h00, irq}, 8'h01, "irq");
        wr(CRFS_OFS_FLAGS, 8'h10);
        @(posedge ref_clk) oq <= 1'b1;
        cyc(3);
        rd(CRFS_OFS_FLAGS, 8'h0B, "flags");
        wr(CRFS_OFS_INTEN, 8'h02);
        cyc(2);
        check({7'h00, irq}, 8'h01, "irq");
        wr(CRFS_OFS_FLAGS, 8'h0B);
        rd(CRFS_OFS_FLAGS, 8'h09, "flags");
        done("status");
        @(posedge ref_clk) {sp, wp} <= 2'b01;
        wr(CRFS_OFS_CLKSEL, 8'h00);
        rd(CRFS_OFS_CLKSEL, 8'h80, "clksel");
        @(posedge ref_clk) wp <= 1'b0;
        wr(CRFS_OFS_CLKSEL, 8'h13);
        #1;
        check({6'h00, tick_restart, wd_restart}, 8'h03, "restarts");
        rd(CRFS_OFS_CLKSEL, 8'h13, "clksel");
        check({sys_from_pll, tick_src, 4'h0, wd_src}, 8'h42, "sources");
        @(posedge ref_clk) wo <= 1'b1;
        wr(CRFS_OFS_CLKSEL, 8'h00);
        rd(CRFS_OFS_CLKSEL, 8'h11, "clksel");
        @(posedge ref_clk) oq <= 1'b0;
        cyc(3);
        rd(CRFS_OFS_CLKSEL, 8'h90, "clksel");
        rd(CRFS_OFS_FLAGS, 8'h0A, "flags");
        @(posedge ref_clk) oq <= 1'b1;
        cyc(3);
        wr(CRFS_OFS_CLKSEL, 8'h01);
        rd(CRFS_OFS_CLKSEL, 8'h11, "clksel");
        @(posedge ref_clk) sp <= 1'b1;
        wr(CRFS_OFS_CLKSEL, 8'h00);
        rd(CRFS_OFS_CLKSEL, 8'h00, "clksel");
        check({6'h00, wd_src}, 8'h00, "wd_src");
        wr(CRFS_OFS_CLKSEL, 8'h01);
        cyc(2);
        check({6'h00, wd_src}, 8'h01, "wd_src");
        done("clock select");
        wr(CRFS_OFS_FLAGS, 8'h02);
        @(posedge ref_clk) st <= 1'b1;
        cyc(3);
        check({7'h00, osc_enable}, 8'h00, "osc_enable");
        rd(CRFS_OFS_FLAGS, 8'h0A, "flags");
        rd(CRFS_OFS_CLKSEL, 8'h80, "clksel");
        @(posedge ref_clk) st <= 1'b0;
        cyc(3);
        wr(CRFS_OFS_CLKSEL, 8'h4F);
        @(posedge ref_clk) st <= 1'b1;
        cyc(3);
        check({5'h00, osc_enable, tick_run, wd_run}, 8'h07, "stop runs");
        @(posedge ref_clk) st <= 1'b0;
        wr(CRFS_OFS_CLKSEL, 8'h40);
        @(posedge ref_clk) st <= 1'b1;
        cyc(3);
        check({5'h00, osc_enable, tick_run, wd_run}, 8'h04, "stop runs");
        @(posedge ref_clk) st <= 1'b0;
        wr(CRFS_OFS_CLKSEL, 8'h70);
        // Two aclk ticks after leaving stop before entering it again
        pulse(6'h20);
        pulse(6'h20);
        @(posedge ref_clk) st <= 1'b1;
        pulse(6'h20);
        cyc(2);
        check({7'h00, aclk_gate}, 8'h00, "aclk_gate");
        pulse(6'h20);
        cyc(2);
        check({7'h00, aclk_gate}, 8'h01, "aclk_gate");
        @(posedge ref_clk) st <= 1'b0;
        done("stop");
        results();
    end
endmodule
